// ---- hdl/pdc_pkg.sv ----
// package for the output pll and clock distribution control block
// assumes a single core clock; the vcxo input is sampled as a level
package pdc_pkg;

  // register offsets
  localparam logic [9:0] REG_VCO_CTRL = 10'h0F3;
  localparam logic [9:0] REG_STATUS   = 10'h22D;
  localparam logic [9:0] REG_SYNC     = 10'h232;
  localparam logic [9:0] REG_UPDATE   = 10'h234;

  // field positions
  localparam int BIT_CAL_REQ  = 1;
  localparam int BIT_CAL_BUSY = 0;
  localparam int BIT_LOCKED   = 1;
  localparam int BIT_SYNC_DIV = 0;
  localparam int BIT_UPDATE   = 0;

  // reset values
  localparam logic [7:0] RST_VCO_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNC     = 8'h00;

  // feedback divider and vco divider limits
  localparam logic [7:0] PRESCALE_P = 8'h04;
  localparam logic [5:0] B_MIN      = 6'h03;
  localparam logic [2:0] M_MIN      = 3'h3;
  localparam logic [2:0] M_MAX      = 3'h5;

  // distribution shape
  localparam int NUM_CH      = 14;
  localparam int CH_DIV_W    = 10;
  localparam int NUM_BYPASS  = 4;
  localparam int SRC_SEL_LO  = 4;
  localparam int SRC_SEL_HI  = 9;
  localparam int SPLIT_CH    = 10;

  // calibration length in vcxo rising edges
  localparam int CAL_VCXO_EDGES = 64;

  // static configuration from the host
  typedef struct packed {
    logic                              doubler_en;
    logic [5:0]                        b_cnt;
    logic [1:0]                        a_cnt;
    logic [2:0]                        vd1_div;
    logic [2:0]                        vd2_div;
    logic [NUM_CH-1:0]                 src_sel_vd2;
    logic [NUM_BYPASS-1:0]             vcxo_bypass;
    logic [NUM_CH-1:0][CH_DIV_W-1:0]   ch_div;
    logic [NUM_CH-1:0]                 ch_pd;
    logic [NUM_CH-1:0]                 ch_tristate;
  } pdc_cfg_t;

  // register write request
  typedef struct packed {
    logic       wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } pdc_reg_req_t;

endpackage

// ---- hdl/pdc_div.sv ----
// generic counting divider: toggles its level every ratio input ticks
// assumes ticks and sync are synchronous one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module pdc_div
  import pdc_pkg::*;
#(
  parameter int RATIO_W = 11
)(
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  // control
  input  wire logic               i_tick,
  input  wire logic               i_sync,
  input  wire logic [RATIO_W-1:0] i_ratio,
  // output
  output logic                    o_level,
  output logic                    o_edge
);

  logic [RATIO_W-1:0] cnt_reg;
  wire                hit;

  // ratio zero behaves as one so the counter can never run away
  assign hit = i_tick && (cnt_reg + 1'b1 >= i_ratio);

  // toggle per ratio ticks gives equal high and low, odd ratios too
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= '0;
      o_level <= 1'b0;
      o_edge  <= 1'b0;
    end
    else if (i_sync)
    begin
      cnt_reg <= '0;
      o_level <= 1'b0;
      o_edge  <= 1'b0;
    end
    else
    begin
      cnt_reg <= hit ? '0 : (i_tick ? cnt_reg + 1'b1 : cnt_reg);
      o_level <= hit ? ~o_level : o_level;
      o_edge  <= hit;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/pdc_vcocal.sv ----
// vco calibration sequencer that advances only on vcxo rising edges
// assumes i_vcxo is synchronous to the core clock
`timescale 1ns/100ps
`default_nettype none
module pdc_vcocal
  import pdc_pkg::*;
#(
  parameter int CAL_EDGES = CAL_VCXO_EDGES
)(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_vcxo,
  input  wire logic i_start,
  // status
  output logic      o_busy,
  output logic      o_done
);

  logic [15:0] cnt_reg;
  logic        vcxo_reg;
  wire         vcxo_rise;
  wire         last;

  // with no vcxo edges the calibration simply stalls
  assign vcxo_rise = i_vcxo && !vcxo_reg;
  assign last      = vcxo_rise && (cnt_reg == 16'(CAL_EDGES - 1));

  // a start while busy is ignored
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg  <= '0;
      vcxo_reg <= 1'b0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
    end
    else
    begin
      vcxo_reg <= i_vcxo;
      o_done   <= o_busy && last;
      if (!o_busy && i_start)
      begin
        o_busy  <= 1'b1;
        cnt_reg <= '0;
      end
      else if (o_busy && vcxo_rise)
      begin
        o_busy  <= !last;
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// ---- hdl/pdc_top.sv ----
// output pll digital control, vco calibration and clock distribution
// assumes one core clock, each cycle being one vco half period;
// vcxo, sync pin and lock are synchronous levels
//
// Functional notes
// - optional doubler makes a pfd tick on both vcxo edges
// - feedback divides by four times b plus a, prescaler fixed
// - b counter limited to 3..63, a counter to 0..3
// - each vco divider divides by 3, 4 or 5
// - vco dividers ignore distribution sync
// - calibration starts on rising calibration request bit only
// - status bit 0 reads one while calibration runs
// - stored configuration with request set calibrates after load
// - calibration stepped by vcxo edges; host supplies vcxo and setup
// - distribution held in sync until first calibration and lock
// - channels four to nine pick first or second vco divider
// - fourteen channels each with own divider and driver
// - vcxo can feed first four outputs directly
// - channel ratio from ten bit field, 1 to 1024
// - channel outputs have fifty percent duty at every ratio
// - per channel power down turns its driver off
// - all channels down puts distribution in deep sleep
// - tristate silences driver while divider keeps in sync
// - falling sync bit or sync pin syncs channel dividers
`timescale 1ns/100ps
`default_nettype none
module pdc_top
  import pdc_pkg::*;
#(
  parameter int CAL_EDGES = CAL_VCXO_EDGES
)(
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  // register access
  input  wire pdc_reg_req_t       i_reg_req,
  input  wire logic [9:0]         i_reg_raddr,
  output logic [7:0]              o_reg_rdata,
  // stored configuration load
  input  wire logic               i_nv_load,
  input  wire logic [7:0]         i_nv_vco_ctrl,
  // static configuration
  input  wire pdc_cfg_t           i_cfg,
  // pins and analog status
  input  wire logic               i_vcxo_clk,
  input  wire logic               i_dist_sync_n,
  input  wire logic               i_pll_locked,
  // pll side strobes
  output logic                    o_pfd_ref_tick,
  output logic                    o_fb_tick,
  output logic                    o_vd1_clk,
  output logic                    o_vd2_clk,
  // distribution
  output logic [NUM_CH-1:0]       o_clk_out,
  output logic [NUM_CH-1:0]       o_out_en,
  output logic                    o_deep_sleep,
  output logic                    o_dist_hold,
  output logic                    o_cal_busy
);

  logic [7:0]        vco_ctrl_buf_reg;
  logic [7:0]        vco_ctrl_act_reg;
  logic [7:0]        sync_buf_reg;
  logic [7:0]        sync_act_reg;
  logic              cal_req_prev_reg;
  logic              sync_prev_reg;
  logic              vcxo_prev_reg;
  logic              hold_reg;
  logic              cal_seen_reg;
  logic [7:0]        rdata_next;
  wire [NUM_CH-1:0]  clk_next;
  wire               wr_vco;
  wire               wr_sync;
  wire               update;
  wire               cal_start;
  wire               cal_busy;
  wire               cal_done;
  wire               sw_sync;
  wire               dist_sync;
  wire               deep_sleep;
  wire               vcxo_rise;
  wire               vcxo_fall;
  wire               ref_tick;
  wire [5:0]         b_eff;
  wire [2:0]         vd1_eff;
  wire [2:0]         vd2_eff;
  wire [7:0]         n_div;
  wire [10:0]        fb_ratio;
  wire               vd1_lvl;
  wire               vd1_edge;
  wire               vd2_lvl;
  wire               vd2_edge;
  wire [NUM_CH-1:0]  ch_lvl;
  wire [NUM_CH-1:0]  drv_off;

  // register decode; writes land in the buffered set only
  assign wr_vco  = i_reg_req.wr && (i_reg_req.addr == REG_VCO_CTRL);
  assign wr_sync = i_reg_req.wr && (i_reg_req.addr == REG_SYNC);
  assign update  = i_reg_req.wr && (i_reg_req.addr == REG_UPDATE)
                   && i_reg_req.wdata[BIT_UPDATE];

  // buffered and active register sets
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      vco_ctrl_buf_reg <= RST_VCO_CTRL;
      vco_ctrl_act_reg <= RST_VCO_CTRL;
      sync_buf_reg     <= RST_SYNC;
      sync_act_reg     <= RST_SYNC;
    end
    else if (i_nv_load)
    begin
      vco_ctrl_buf_reg <= i_nv_vco_ctrl;
      vco_ctrl_act_reg <= i_nv_vco_ctrl;
    end
    else
    begin
      vco_ctrl_buf_reg <= wr_vco ? i_reg_req.wdata : vco_ctrl_buf_reg;
      sync_buf_reg     <= wr_sync ? i_reg_req.wdata : sync_buf_reg;
      vco_ctrl_act_reg <= update ? vco_ctrl_buf_reg
                                 : vco_ctrl_act_reg;
      sync_act_reg     <= update ? sync_buf_reg : sync_act_reg;
    end
  end

  // edge detection on the active bits; hardware never clears them
  assign cal_start = vco_ctrl_act_reg[BIT_CAL_REQ]
                     && !cal_req_prev_reg;
  assign sw_sync   = !sync_act_reg[BIT_SYNC_DIV]
                     && sync_prev_reg;
  assign dist_sync = sw_sync || !i_dist_sync_n || hold_reg
                     || deep_sleep;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cal_req_prev_reg <= 1'b0;
      sync_prev_reg    <= 1'b0;
      vcxo_prev_reg    <= 1'b0;
    end
    else
    begin
      cal_req_prev_reg <= vco_ctrl_act_reg[BIT_CAL_REQ];
      sync_prev_reg    <= sync_act_reg[BIT_SYNC_DIV];
      vcxo_prev_reg    <= i_vcxo_clk;
    end
  end

  // calibration sequencer stepped by the vcxo input
  pdc_vcocal #(
    .CAL_EDGES (CAL_EDGES)
  ) u_cal (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_vcxo     (i_vcxo_clk),
    .i_start    (cal_start),
    .o_busy     (cal_busy),
    .o_done     (cal_done)
  );

  // startup hold; later lock changes do not resync
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hold_reg     <= 1'b1;
      cal_seen_reg <= 1'b0;
    end
    else
    begin
      cal_seen_reg <= cal_seen_reg || cal_done;
      hold_reg     <= hold_reg
                      && !(cal_seen_reg && i_pll_locked);
    end
  end

  // doubler: both vcxo edges feed the pfd when enabled
  assign vcxo_rise = i_vcxo_clk && !vcxo_prev_reg;
  assign vcxo_fall = !i_vcxo_clk && vcxo_prev_reg;
  assign ref_tick  = vcxo_rise
                     || (i_cfg.doubler_en && vcxo_fall);

  // out of range settings are clamped rather than trusted
  assign b_eff  = (i_cfg.b_cnt < B_MIN) ? B_MIN : i_cfg.b_cnt;
  assign vd1_eff = (i_cfg.vd1_div < M_MIN) ? M_MIN :
                  (i_cfg.vd1_div > M_MAX) ? M_MAX : i_cfg.vd1_div;
  assign vd2_eff = (i_cfg.vd2_div < M_MIN) ? M_MIN :
                  (i_cfg.vd2_div > M_MAX) ? M_MAX : i_cfg.vd2_div;
  assign n_div  = 8'(PRESCALE_P * {2'h0, b_eff})
                  + {6'h00, i_cfg.a_cnt};
  assign fb_ratio = {2'h0, n_div, 1'b0}; // two half periods per vco period

  // feedback divider
  pdc_div #(
    .RATIO_W (11)
  ) u_fb (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_tick     (1'b1),
    .i_sync     (1'b0),
    .i_ratio    (fb_ratio),
    .o_level    (),
    .o_edge     (o_fb_tick)
  );

  // vco dividers never see the distribution sync
  pdc_div #(
    .RATIO_W (11)
  ) u_vd1 (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_tick     (1'b1),
    .i_sync     (1'b0),
    .i_ratio    ({8'h00, vd1_eff}),
    .o_level    (vd1_lvl),
    .o_edge     (vd1_edge)
  );

  pdc_div #(
    .RATIO_W (11)
  ) u_vd2 (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_tick     (1'b1),
    .i_sync     (1'b0),
    .i_ratio    ({8'h00, vd2_eff}),
    .o_level    (vd2_lvl),
    .o_edge     (vd2_edge)
  );

  assign deep_sleep = &i_cfg.ch_pd;

  // channel dividers count vco divider edges, so ratio d toggles
  // every d vco divider half periods and stays at fifty percent duty
  generate
    for (genvar k = 0; k < NUM_CH; k++)
    begin : g_ch
      wire       use_vd2;
      wire       src_edge;
      wire       src_lvl;
      wire [10:0] ratio;
      if (k >= SRC_SEL_LO && k <= SRC_SEL_HI)
      begin : g_sel
        assign use_vd2 = i_cfg.src_sel_vd2[k];
      end
      else
      begin : g_fix
        assign use_vd2 = (k >= SPLIT_CH);
      end
      assign src_edge = use_vd2 ? vd2_edge : vd1_edge;
      assign src_lvl  = use_vd2 ? vd2_lvl : vd1_lvl;
      assign ratio    = {1'b0, i_cfg.ch_div[k]} + 11'h001;
      pdc_div #(
        .RATIO_W (11)
      ) u_d (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_tick     (src_edge),
        .i_sync     (dist_sync),
        .i_ratio    (ratio),
        .o_level    (ch_lvl[k]),
        .o_edge     ()
      );
      // tristate only gates the driver; the divider runs on
      assign drv_off[k] = hold_reg || i_cfg.ch_pd[k]
                          || i_cfg.ch_tristate[k];
      if (k < NUM_BYPASS)
      begin : g_byp
        assign clk_next[k] = drv_off[k] ? 1'b0 :
                             i_cfg.vcxo_bypass[k] ? i_vcxo_clk
                                                  : ch_lvl[k];
      end
      else
      begin : g_div
        assign clk_next[k] = drv_off[k] ? 1'b0 : ch_lvl[k];
      end
    end
  endgenerate

  // readback mux; unmapped offsets read zero
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (i_reg_raddr)
      REG_VCO_CTRL: rdata_next = vco_ctrl_buf_reg;
      REG_SYNC:     rdata_next = sync_buf_reg;
      REG_STATUS:
      begin
        rdata_next[BIT_CAL_BUSY] = cal_busy;
        rdata_next[BIT_LOCKED]   = i_pll_locked;
      end
      default:      rdata_next = 8'h00;
    endcase
  end

  // all outputs registered
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata    <= 8'h00;
      o_pfd_ref_tick <= 1'b0;
      o_vd1_clk      <= 1'b0;
      o_vd2_clk      <= 1'b0;
      o_clk_out      <= '0;
      o_out_en       <= '0;
      o_deep_sleep   <= 1'b0;
      o_dist_hold    <= 1'b1;
      o_cal_busy     <= 1'b0;
    end
    else
    begin
      o_reg_rdata    <= rdata_next;
      o_pfd_ref_tick <= ref_tick;
      o_vd1_clk      <= vd1_lvl;
      o_vd2_clk      <= vd2_lvl;
      o_clk_out      <= clk_next;
      o_out_en       <= ~drv_off;
      o_deep_sleep   <= deep_sleep;
      o_dist_hold    <= hold_reg;
      o_cal_busy     <= cal_busy;
    end
  end

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_req_low_then_high;
    !vco_ctrl_act_reg[BIT_CAL_REQ] ##1 vco_ctrl_act_reg[BIT_CAL_REQ];
  endsequence

  a_cal_edge_start: assert property (
    s_req_low_then_high |-> ##[1:2] o_cal_busy)
    else $error("calibration did not start on request edge");
  a_write_no_effect: assert property (
    wr_vco && !update && !i_nv_load |=> $stable(vco_ctrl_act_reg))
    else $error("active control changed without update");
  a_status_busy: assert property (
    i_reg_raddr == REG_STATUS |=> o_reg_rdata[0] == $past(cal_busy))
    else $error("status busy bit wrong");
  a_hold_outputs: assert property (
    hold_reg |=> o_out_en == '0 && o_clk_out == '0)
    else $error("output active during startup hold");
  a_pd_driver: assert property (
    i_cfg.ch_pd[0] |=> !o_out_en[0])
    else $error("powered down channel still driving");
  a_deep_sleep_all: assert property (
    &i_cfg.ch_pd |=> o_deep_sleep)
    else $error("deep sleep missing");
  a_sw_sync_fall: assert property (
    $fell(sync_act_reg[BIT_SYNC_DIV]) |=> !ch_lvl[5])
    else $error("software sync ignored");
  a_vd1_spacing: assert property (
    vd1_edge |=> !vd1_edge [*2])
    else $error("vco divider below three");
  a_doubler_fall: assert property (
    i_cfg.doubler_en && vcxo_fall |=> o_pfd_ref_tick)
    else $error("doubler missed falling edge");
  a_fb_min: assert property (
    n_div >= PRESCALE_P * {2'h0, B_MIN})
    else $error("feedback ratio below minimum");

endmodule
`default_nettype wire

// ---- hdl/pdc_fix_unused.sv ----
// holds no logic; the block's modules live in the other design files
// assumes nothing of its surroundings
`default_nettype none
`default_nettype wire

// ---- dv/pdc_host_model.sv ----
// host controller model: writes and reads the device registers
// assumes the bench calls its tasks and that core clock runs freely
`timescale 1ns/100ps
`default_nettype none
module pdc_host_model
  import pdc_pkg::*;
(
  // clock
  input  wire logic         i_core_clk,
  // read data from the device
  input  wire logic [7:0]   i_reg_rdata,
  // requests to the device
  output pdc_reg_req_t      o_reg_req,
  output logic [9:0]        o_reg_raddr
);
  // idle bus at time zero
  initial
  begin
    o_reg_req   = '0;
    o_reg_raddr = '0;
  end

  // one-cycle write pulse; a free edge passes before the next one
  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    @(posedge i_core_clk);
    o_reg_req <= '{wr: 1'b1, addr: addr, wdata: data};
    @(posedge i_core_clk);
    o_reg_req <= '{wr: 1'b0, addr: addr, wdata: ~data};
  endtask

  // data is registered, so it is taken two edges after the address
  task automatic rd(input logic [9:0] addr, output logic [7:0] data);
    @(posedge i_core_clk);
    o_reg_raddr <= addr;
    @(posedge i_core_clk);
    @(posedge i_core_clk);
    data = i_reg_rdata;
  endtask

  // transfer buffered registers to the active set
  task automatic update();
    wr(REG_UPDATE, 8'h01);
  endtask

  // request must fall and rise in the active set to start again
  task automatic recal();
    wr(REG_VCO_CTRL, 8'h00);
    update();
    wr(REG_VCO_CTRL, 8'h02);
    update();
  endtask

  // software sync: the update after the clearing write is the event
  task automatic sw_sync();
    wr(REG_SYNC, 8'h01);
    update();
    wr(REG_SYNC, 8'h00);
    update();
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the pll control and distribution block
// assumes the host model file is compiled before this one
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pdc_pkg::*;
  localparam int CAL_E = 4;
  typedef struct packed {
    logic [9:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  exp;
  } pdc_reg_row_t;
  typedef struct packed {
    logic [5:0]  b;
    logic [1:0]  a;
    logic [2:0]  m;
    logic [9:0]  d;
    logic [31:0] fb;
    logic [31:0] ch;
  } pdc_div_row_t;

  logic                i_core_clk;
  logic                i_rst_n;
  pdc_reg_req_t        reg_req;
  logic [9:0]          reg_raddr;
  logic [7:0]          reg_rdata;
  logic                nv_load;
  logic [7:0]          nv_ctrl;
  pdc_cfg_t            cfg;
  logic                vcxo;
  logic                sync_n;
  logic                locked;
  logic                pfd_tick;
  logic                fb_tick;
  logic                vd1_clk;
  logic                vd2_clk;
  logic [NUM_CH-1:0]   clk_out;
  logic [NUM_CH-1:0]   out_en;
  logic                deep_sleep;
  logic                dist_hold;
  logic                cal_busy;
  int                  failures = 0;
  int                  checked = 0;
  int                  cycles = 0;
  int                  vcnt = 0;
  int                  hi;
  int                  lo;
  int                  n;
  logic [7:0]          rdat;

  // register cases: write, read back, expected value
  pdc_reg_row_t reg_rows [6] = '{
    '{10'h0F3, 8'hA5, 8'hA5}, '{10'h232, 8'h3C, 8'h3C},
    '{10'h100, 8'hFF, 8'h00}, '{10'h234, 8'h00, 8'h00},
    '{10'h22D, 8'hFF, 8'h00}, '{10'h0F3, 8'h02, 8'h02}};
  // divider cases; b of 2 is clamped up to 3
  pdc_div_row_t div_rows [4] = '{
    '{6'h03, 2'h0, 3'h3, 10'h000, 32'h18, 32'h06},
    '{6'h05, 2'h3, 3'h4, 10'h002, 32'h2E, 32'h18},
    '{6'h3F, 2'h3, 3'h5, 10'h004, 32'h1FE, 32'h32},
    '{6'h02, 2'h1, 3'h3, 10'h006, 32'h1A, 32'h2A}};

  pdc_host_model host_i (
    .i_core_clk (i_core_clk), .i_reg_rdata (reg_rdata),
    .o_reg_req  (reg_req),    .o_reg_raddr (reg_raddr));

  pdc_top #(.CAL_EDGES(CAL_E)) pdc_top_i (
    .i_core_clk     (i_core_clk), .i_rst_n        (i_rst_n),
    .i_reg_req      (reg_req),    .i_reg_raddr    (reg_raddr),
    .o_reg_rdata    (reg_rdata),  .i_nv_load      (nv_load),
    .i_nv_vco_ctrl  (nv_ctrl),    .i_cfg          (cfg),
    .i_vcxo_clk     (vcxo),       .i_dist_sync_n  (sync_n),
    .i_pll_locked   (locked),     .o_pfd_ref_tick (pfd_tick),
    .o_fb_tick      (fb_tick),    .o_vd1_clk      (vd1_clk),
    .o_vd2_clk      (vd2_clk),    .o_clk_out      (clk_out),
    .o_out_en       (out_en),     .o_deep_sleep   (deep_sleep),
    .o_dist_hold    (dist_hold),  .o_cal_busy     (cal_busy));

  // 50 MHz core clock
  initial
  begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // vcxo level with a ten cycle period, kept synchronous to the core
  always @(posedge i_core_clk)
  begin
    vcnt <= (vcnt == 4) ? 0 : vcnt + 1;
    if (vcnt == 4)
      vcxo <= ~vcxo;
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures++;
      complete_run();
    end
  end

  // one output picked by index, so one measuring task serves all
  function automatic logic sel(input int k);
    if (k < NUM_CH)
      return clk_out[k];
    case (k)
      14: return vd1_clk;
      15: return vd2_clk;
      16: return fb_tick;
      17: return cal_busy;
      // divider level behind a silenced driver
      19: return pdc_top_i.ch_lvl[1];
      default: return dist_hold;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // full high and low time after the next rise, sampled at falling edges
  task automatic meas(input int k, output int h, output int l);
    int w;
    w = 0;
    while (sel(k) !== 1'b0 && w < 3000) begin @(negedge i_core_clk); w++; end
    while (sel(k) !== 1'b1 && w < 3000) begin @(negedge i_core_clk); w++; end
    h = 0;
    l = 0;
    while (sel(k) === 1'b1 && h < 3000) begin @(negedge i_core_clk); h++; end
    while (sel(k) === 1'b0 && l < 3000) begin @(negedge i_core_clk); l++; end
  endtask

  // bounded wait for a level, then compare it
  task automatic wait_lvl(input int k, input logic v, input int lim);
    int w;
    w = 0;
    while (sel(k) !== v && w < lim) begin @(negedge i_core_clk); w++; end
    chk(sel(k), v);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    vcxo = 1'b0;
    nv_load = 1'b0;
    nv_ctrl = 8'h00;
    sync_n = 1'b1;
    locked = 1'b0;
    cfg = '0;
    cfg.b_cnt = 6'h03;
    cfg.vd1_div = 3'h3;
    cfg.vd2_div = 3'h5;
    repeat (16) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk({dist_hold, cal_busy, out_en}, {2'h2, 14'h0000});
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    // register table; last row leaves the request set but not updated
    foreach (reg_rows[i])
    begin
      host_i.wr(reg_rows[i].addr, reg_rows[i].wdata);
      host_i.rd(reg_rows[i].addr, rdat);
      chk(rdat, reg_rows[i].exp);
    end
    repeat (20) @(negedge i_core_clk);
    chk(cal_busy, 1'b0);
    host_i.update();
    wait_lvl(17, 1'b1, 20);
    host_i.rd(REG_STATUS, rdat);
    chk(rdat, 8'h01);
    // calibration length counted in vcxo rises
    n = 0;
    while (cal_busy === 1'b1 && n < CAL_E + 3)
    begin
      @(posedge vcxo);
      @(negedge i_core_clk);
      n++;
    end
    chk(n >= CAL_E - 1 && n <= CAL_E + 1, 1'b1);
    repeat (10) @(negedge i_core_clk);
    chk({dist_hold, clk_out}, {1'b1, 14'h0000});
    host_i.rd(REG_STATUS, rdat);
    chk(rdat, 8'h00);
    @(posedge i_core_clk);
    locked <= 1'b1;
    wait_lvl(18, 1'b0, 6);
    // request still set: a second update must not restart
    host_i.update();
    repeat (20) @(negedge i_core_clk);
    chk(cal_busy, 1'b0);
    host_i.recal();
    wait_lvl(17, 1'b1, 20);
    wait_lvl(17, 1'b0, 100);
    host_i.sw_sync();
    // feedback, vco divider and channel ratios
    foreach (div_rows[i])
    begin
      @(posedge i_core_clk);
      cfg.b_cnt <= div_rows[i].b;
      cfg.a_cnt <= div_rows[i].a;
      cfg.vd1_div <= div_rows[i].m;
      cfg.ch_div[0] <= div_rows[i].d;
      meas(16, hi, lo);
      meas(16, hi, lo);
      chk(hi + lo, div_rows[i].fb);
      meas(14, hi, lo);
      meas(14, hi, lo);
      chk(hi, div_rows[i].m);
      chk(lo, div_rows[i].m);
      meas(0, hi, lo);
      meas(0, hi, lo);
      chk(hi + lo, div_rows[i].ch);
      chk(hi, lo);
    end
    // doubler off then on over a whole number of vcxo periods
    for (int dbl = 0; dbl < 2; dbl++)
    begin
      @(posedge i_core_clk);
      cfg.doubler_en <= dbl[0];
      repeat (3) @(negedge i_core_clk);
      n = 0;
      repeat (100) begin @(negedge i_core_clk); n += pfd_tick; end
      chk(n, 10 + 10 * dbl);
    end
    // channel four on either vco divider, ratio two
    for (int s = 0; s < 2; s++)
    begin
      @(posedge i_core_clk);
      cfg.src_sel_vd2[4] <= s[0];
      cfg.ch_div[4] <= 10'h001;
      meas(4, hi, lo);
      meas(4, hi, lo);
      chk(hi + lo, 12 + 8 * s);
    end
    @(posedge i_core_clk);
    cfg.vcxo_bypass[0] <= 1'b1;
    meas(0, hi, lo);
    meas(0, hi, lo);
    chk(hi, 32'h5);
    chk(lo, 32'h5);
    @(posedge i_core_clk);
    cfg.vcxo_bypass[0] <= 1'b0;
    cfg.ch_tristate[1] <= 1'b1;
    cfg.ch_pd[2] <= 1'b1;
    repeat (3) @(negedge i_core_clk);
    chk({out_en[3:1], deep_sleep}, 4'h8);
    meas(19, hi, lo);
    chk(hi + lo, 32'h6);
    @(posedge i_core_clk);
    cfg.ch_pd <= '1;
    repeat (3) @(negedge i_core_clk);
    chk(deep_sleep, 1'b1);
    @(posedge i_core_clk);
    cfg.ch_pd <= '0;
    cfg.ch_tristate <= '0;
    sync_n <= 1'b0;
    repeat (3) @(negedge i_core_clk);
    chk(clk_out, 14'h0000);
    meas(14, hi, lo);
    chk(hi, 32'h3);
    meas(15, hi, lo);
    chk(lo, 32'h5);
    @(posedge i_core_clk);
    sync_n <= 1'b1;
    cfg.ch_div[0] <= 10'h063;
    wait_lvl(0, 1'b1, 800);
    host_i.sw_sync();
    repeat (3) @(negedge i_core_clk);
    chk(clk_out[0], 1'b0);
    // second reset in mid-run, then stored configuration load
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    nv_ctrl <= 8'h02;
    @(negedge i_core_clk);
    chk({cal_busy, dist_hold}, 2'h1);
    @(posedge i_core_clk);
    nv_load <= 1'b1;
    @(posedge i_core_clk);
    nv_load <= 1'b0;
    wait_lvl(17, 1'b1, 20);
    complete_run();
  end
endmodule
`default_nettype wire
